// [inc/fro_pkg.sv]
package fro_pkg;

    // register port offsets
    localparam logic [3:0] REG_WOC_OFS = 4'h0;
    localparam logic [3:0] REG_FPC_OFS = 4'h1;
    localparam logic [3:0] REG_STAT_OFS = 4'h2;

    // wait/overlay control fields
    localparam int WOC_SEL_HI_BIT = 7;
    localparam int WOC_SEL_LO_BIT = 6;
    localparam logic [7:0] WOC_RESET = 8'h08;

    // flash program control fields
    localparam int FPC_PROG_BIT = 0;
    localparam int FPC_ERASE_BIT = 1;
    localparam int FPC_PV_BIT = 2;
    localparam int FPC_EV_BIT = 3;
    localparam logic [7:0] FPC_RESET = 8'h00;
    localparam logic [7:0] FPC_USED_MASK = 8'h0f;

    // status fields
    localparam int STAT_OVL_BIT = 0;
    localparam int STAT_ABORT_BIT = 1;
    localparam int STAT_BUSY_BIT = 2;
    localparam int STAT_EMU_PROT_BIT = 3;

    // overlay windows
    localparam logic [15:0] RAM_BASE_VEC = 16'hf800;
    localparam logic [15:0] RAM_LAST_VEC = 16'hf87f;
    localparam logic [15:0] FL_BASE_VEC = 16'h0000;
    localparam logic [15:0] FL_LAST_VEC = 16'h007f;
    localparam logic [15:0] RAM_BASE_SB = 16'hf880;
    localparam logic [15:0] RAM_LAST_SB1 = 16'hf8ff;
    localparam logic [15:0] RAM_LAST_SB2 = 16'hf97f;
    localparam logic [15:0] FL_BASE_SB = 16'h0080;
    localparam logic [15:0] FL_LAST_SB1 = 16'h00ff;
    localparam logic [15:0] FL_LAST_SB2 = 16'h017f;

    // overlay select patterns
    typedef enum logic [1:0] {
        FRO_OVL_NONE = 2'h0,
        FRO_OVL_SB1 = 2'h1,
        FRO_OVL_SB2 = 2'h2,
        FRO_OVL_VEC = 2'h3
    } fro_ovl_t;

    // cpu memory request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
    } fro_mreq_t;

    // decoded memory route
    typedef struct packed {
        logic to_ram;
        logic to_flash;
        logic flash_invalid;
        logic [15:0] addr;
    } fro_route_t;

endpackage

// [src/fro_window.sv]
`timescale 1ns/1ns
// one overlay window match and translation
module fro_window (
    input wire logic [15:0] addr_i,
    input wire logic enable_i,
    input wire logic [15:0] fl_base_i,
    input wire logic [15:0] fl_last_i,
    input wire logic [15:0] ram_base_i,
    output logic hit_o,
    output logic [15:0] ram_addr_o
);
    // range compare and rebase into ram
    always_comb begin
        hit_o = enable_i && (addr_i >= fl_base_i) && (addr_i <= fl_last_i);
        ram_addr_o = 16'(addr_i - fl_base_i + ram_base_i);
    end
endmodule // fro_window

// [src/fro_overlay.sv]
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ns
// Summary of operation
// - interrupt while armed aborts program or erase
// - aborted cells undefined, no value guaranteed
// - flash reads invalid while arm bit set
// - pattern 11 plus vpp maps vector ram
// - vectors then fetched from ram, not flash
// - bits 7:6 select one of three overlays or none
// - overlaid ram answers at both addresses
// - reset and hw standby init control register
// - boot mode: overlay on, only nmi accepted
// - boot leaves both bits set; clear removes
// - one select bit set blocks program/erase
module fro_overlay (
    // clock, reset and standby
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic hw_standby_i,
    // boot strap, programming voltage and interrupts
    input wire logic boot_mode_i,
    input wire logic boot_done_i,
    input wire logic flash_high_voltage_pin_i,
    input wire logic nmi_i,
    input wire logic irq_i,
    // cpu memory access to be routed
    input wire fro_pkg::fro_mreq_t cpu_req_i,
    // register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // routing result and flash control status
    output fro_pkg::fro_route_t route_o,
    output logic [1:0] ovl_select_o,
    output logic prog_active_o,
    output logic erase_active_o,
    output logic flash_abort_o,
    output logic nmi_take_o,
    output logic irq_take_o
);
    // boot progress states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_BOOT = 3'b010,
        ST_USER = 3'b100
    } fro_boot_t;

    // whole module state
    typedef struct packed {
        // software visible registers
        logic [7:0] woc;
        logic [7:0] fpc;
        // abort latch, cleared by reset only
        logic aborted;
        // registered answers
        logic [7:0] rdata;
        fro_pkg::fro_route_t route;
        logic prog;
        logic erase;
        // one cycle pulses, then boot progress
        logic abort_p;
        logic nmi_t;
        logic irq_t;
        fro_boot_t boot;
    } fro_state_t;

    fro_state_t s_q;
    fro_state_t s_d;

    // overlay decode and window hits
    logic [1:0] sel;
    logic vec_en;
    logic sb1_en;
    logic sb2_en;
    logic hit_vec;
    logic hit_sb1;
    logic hit_sb2;
    logic [15:0] ram_vec;
    logic [15:0] ram_sb1;
    logic [15:0] ram_sb2;
    // program control and interrupt qualifiers
    logic armed;
    logic emu_protect;
    logic irq_ok;
    logic any_int;

    assign sel = {s_q.woc[fro_pkg::WOC_SEL_HI_BIT], s_q.woc[fro_pkg::WOC_SEL_LO_BIT]};
    // vector overlay only with vpp present
    assign vec_en = (sel == fro_pkg::FRO_OVL_VEC) && flash_high_voltage_pin_i;
    assign sb1_en = (sel == fro_pkg::FRO_OVL_SB1);
    assign sb2_en = (sel == fro_pkg::FRO_OVL_SB2);
    // exactly one select bit set means emulation in progress
    assign emu_protect = sel[1] ^ sel[0];
    // either arm bit makes flash reads unreliable
    assign armed = s_q.fpc[fro_pkg::FPC_PROG_BIT] | s_q.fpc[fro_pkg::FPC_ERASE_BIT];
    // boot program accepts nmi only
    assign irq_ok = (s_q.boot != ST_BOOT);
    // any accepted interrupt can abort an armed operation
    assign any_int = nmi_i | (irq_i & irq_ok);

    // vector window
    fro_window u_win_vec (
        .addr_i(cpu_req_i.addr),
        .enable_i(vec_en),
        .fl_base_i(fro_pkg::FL_BASE_VEC),
        .fl_last_i(fro_pkg::FL_LAST_VEC),
        .ram_base_i(fro_pkg::RAM_BASE_VEC),
        .hit_o(hit_vec),
        .ram_addr_o(ram_vec)
    );

    // small block window, one block
    fro_window u_win_sb1 (
        .addr_i(cpu_req_i.addr),
        .enable_i(sb1_en),
        .fl_base_i(fro_pkg::FL_BASE_SB),
        .fl_last_i(fro_pkg::FL_LAST_SB1),
        .ram_base_i(fro_pkg::RAM_BASE_SB),
        .hit_o(hit_sb1),
        .ram_addr_o(ram_sb1)
    );

    // small block window, two blocks
    fro_window u_win_sb2 (
        .addr_i(cpu_req_i.addr),
        .enable_i(sb2_en),
        .fl_base_i(fro_pkg::FL_BASE_SB),
        .fl_last_i(fro_pkg::FL_LAST_SB2),
        .ram_base_i(fro_pkg::RAM_BASE_SB),
        .hit_o(hit_sb2),
        .ram_addr_o(ram_sb2)
    );

    // next state
    always_comb begin
        s_d = s_q;
        s_d.abort_p = 1'b0;
        s_d.nmi_t = 1'b0;
        s_d.irq_t = 1'b0;
        s_d.rdata = 8'h00;

        // boot progress
        unique case (s_q.boot)
            // strap looked at every cycle while idle after reset
            ST_IDLE: begin
                if (boot_mode_i) begin
                    s_d.boot = ST_BOOT;
                end
            end
            // boot program running, irq held off
            ST_BOOT: begin
                if (boot_done_i) begin
                    s_d.boot = ST_USER;
                end
            end
            // user program; stays until reset
            ST_USER: begin
                s_d.boot = ST_USER;
            end
            default: begin
                s_d.boot = ST_IDLE;
            end
        endcase

        // register writes; a control write in the cycle of boot entry
        // loses bits 7:6 to the boot setting below
        if (reg_wr_i) begin
            if (reg_addr_i == fro_pkg::REG_WOC_OFS) begin
                s_d.woc = reg_wdata_i;
            end else if (reg_addr_i == fro_pkg::REG_FPC_OFS) begin
                s_d.fpc = reg_wdata_i & fro_pkg::FPC_USED_MASK;
            end
        end
        // entering boot sets the nmi overlay bits
        if (s_q.boot == ST_IDLE && boot_mode_i) begin
            s_d.woc[fro_pkg::WOC_SEL_HI_BIT] = 1'b1;
            s_d.woc[fro_pkg::WOC_SEL_LO_BIT] = 1'b1;
        end

        // interrupt acceptance
        s_d.nmi_t = nmi_i;
        s_d.irq_t = irq_i & irq_ok;

        // abort on interrupt while armed; kept until reset
        // arm bits are retained so software can see what was running
        if (any_int && armed) begin
            s_d.aborted = 1'b1;
            s_d.abort_p = 1'b1;
        end

        // arm bits take effect only when not blocked
        s_d.prog = s_d.fpc[fro_pkg::FPC_PROG_BIT] & flash_high_voltage_pin_i
            & ~emu_protect & ~s_d.aborted;
        s_d.erase = s_d.fpc[fro_pkg::FPC_ERASE_BIT] & flash_high_voltage_pin_i
            & ~emu_protect & ~s_d.aborted;

        // vpp absent clears program control
        if (!flash_high_voltage_pin_i) begin
            s_d.fpc = fro_pkg::FPC_RESET;
        end

        // address routing
        s_d.route.addr = cpu_req_i.addr;
        s_d.route.to_ram = 1'b0;
        s_d.route.to_flash = 1'b0;
        s_d.route.flash_invalid = 1'b0;
        // vector window first, then the small block windows
        if (cpu_req_i.rd || cpu_req_i.wr) begin
            if (hit_vec) begin
                s_d.route.to_ram = 1'b1;
                s_d.route.addr = ram_vec;
            end else if (hit_sb1) begin
                s_d.route.to_ram = 1'b1;
                s_d.route.addr = ram_sb1;
            end else if (hit_sb2) begin
                s_d.route.to_ram = 1'b1;
                s_d.route.addr = ram_sb2;
            end else if (cpu_req_i.addr >= fro_pkg::RAM_BASE_VEC) begin
                // ram keeps answering at its own address
                s_d.route.to_ram = 1'b1;
            end else begin
                s_d.route.to_flash = 1'b1;
                // data not guaranteed while armed or after abort
                s_d.route.flash_invalid = armed | s_q.aborted;
            end
        end

        // register reads; zero outside the answer cycle and when unmapped
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                fro_pkg::REG_WOC_OFS: s_d.rdata = s_q.woc;
                fro_pkg::REG_FPC_OFS: s_d.rdata = s_q.fpc;
                fro_pkg::REG_STAT_OFS: begin
                    s_d.rdata[fro_pkg::STAT_OVL_BIT] = vec_en | sb1_en | sb2_en;
                    s_d.rdata[fro_pkg::STAT_ABORT_BIT] = s_q.aborted;
                    s_d.rdata[fro_pkg::STAT_BUSY_BIT] = s_q.prog | s_q.erase;
                    s_d.rdata[fro_pkg::STAT_EMU_PROT_BIT] = emu_protect;
                end
                default: s_d.rdata = 8'h00;
            endcase
        end

        // hardware standby initialises the control registers and arm outputs like reset
        // software standby has no input here, so the registers hold
        if (hw_standby_i) begin
            s_d.woc = fro_pkg::WOC_RESET;
            s_d.fpc = fro_pkg::FPC_RESET;
            s_d.prog = 1'b0;
            s_d.erase = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // clear all, then control registers to their init values
            s_q <= '0;
            s_q.woc <= fro_pkg::WOC_RESET;
            s_q.fpc <= fro_pkg::FPC_RESET;
            s_q.boot <= ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from state
    assign reg_rdata_o = s_q.rdata;
    assign route_o = s_q.route;
    assign ovl_select_o = {s_q.woc[fro_pkg::WOC_SEL_HI_BIT], s_q.woc[fro_pkg::WOC_SEL_LO_BIT]};
    assign prog_active_o = s_q.prog;
    assign erase_active_o = s_q.erase;
    assign flash_abort_o = s_q.abort_p;
    assign nmi_take_o = s_q.nmi_t;
    assign irq_take_o = s_q.irq_t;
endmodule // fro_overlay

// [bench/fro_overlay_assertions.sv]
`timescale 1ns/1ns
// port level checks of the overlay block
module fro_overlay_assertions (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic hw_standby_i,
    input wire logic flash_high_voltage_pin_i,
    input wire logic nmi_i,
    input wire fro_pkg::fro_mreq_t cpu_req_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire fro_pkg::fro_route_t route_o,
    input wire logic [1:0] ovl_select_o,
    input wire logic prog_active_o,
    input wire logic flash_abort_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // armed flash hit by an nmi
    sequence s_armed_nmi;
        prog_active_o && nmi_i;
    endsequence
    sequence s_abort_done;
        flash_abort_o ##1 !prog_active_o;
    endsequence
    property p_abort;
        s_armed_nmi |=> s_abort_done;
    endproperty
    a_abort: assert property (p_abort) else $error("no abort on nmi");
    property p_inval;
        prog_active_o && cpu_req_i.rd && cpu_req_i.addr[15:11] != 5'h1f && ovl_select_o == 2'h0
            |=> route_o.flash_invalid;
    endproperty
    a_inval: assert property (p_inval) else $error("flash read not invalid");
    property p_vec;
        ovl_select_o == 2'h3 && flash_high_voltage_pin_i && cpu_req_i.rd && cpu_req_i.addr[15:7] == 9'h0
            |=> route_o.to_ram && route_o.addr == $past(cpu_req_i.addr) + 16'hf800;
    endproperty
    a_vec: assert property (p_vec) else $error("vector window wrong");
    property p_sb;
        cpu_req_i.rd && (ovl_select_o == 2'h1 && cpu_req_i.addr[15:7] == 9'h1
            || ovl_select_o == 2'h2 && cpu_req_i.addr >= 16'h0080 && cpu_req_i.addr <= 16'h017f)
            |=> route_o.to_ram && !route_o.to_flash && route_o.addr == $past(cpu_req_i.addr) + 16'hf800;
    endproperty
    a_sb: assert property (p_sb) else $error("small block window wrong");
    property p_ram;
        cpu_req_i.rd && cpu_req_i.addr[15:11] == 5'h1f
            |=> route_o.to_ram && route_o.addr == $past(cpu_req_i.addr);
    endproperty
    a_ram: assert property (p_ram) else $error("ram address moved");
    property p_prot;
        (ovl_select_o[0] ^ ovl_select_o[1]) [*2] |-> !prog_active_o;
    endproperty
    a_prot: assert property (p_prot) else $error("program under emulation");
    property p_stby;
        hw_standby_i |=> ovl_select_o == 2'h0;
    endproperty
    a_stby: assert property (p_stby) else $error("standby kept overlay");
    property p_rdb;
        reg_rd_i && reg_addr_i == fro_pkg::REG_WOC_OFS |=> reg_rdata_o[7:6] == $past(ovl_select_o);
    endproperty
    a_rdb: assert property (p_rdb) else $error("overlay bits misread");
endmodule // fro_overlay_assertions

bind fro_overlay fro_overlay_assertions i_fro_overlay_assertions (.*);

// [bench/fro_overlay_bench.sv]
`timescale 1ns/1ns
// register and route sequences for the overlay block
module fro_overlay_bench;
    logic clk_i = 1'b0, rst_n_i = 1'b0, hw_standby_i = 1'b0, boot_mode_i = 1'b0;
    logic boot_done_i = 1'b0, flash_high_voltage_pin_i = 1'b0, nmi_i = 1'b0, irq_i = 1'b0;
    fro_pkg::fro_mreq_t cpu_req_i = '0;
    logic [3:0] reg_addr_i = 4'h0;
    logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, rdat;
    logic reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    fro_pkg::fro_route_t route_o;
    logic [1:0] ovl_select_o;
    logic prog_active_o, erase_active_o, flash_abort_o, nmi_take_o, irq_take_o;
    logic [15:0] adr [8] = '{16'h0006, 16'h007f, 16'h0080, 16'h00ff, 16'h0100, 16'h017f,
        16'h0180, 16'hf97f};
    int err_count = 0, n_compared = 0;
    always #50 clk_i = ~clk_i;
    fro_overlay i_fro_overlay (.*);
    // result compare and verdict
    task automatic chk(input logic [18:0] got, input logic [18:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        if (err_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // register port and cpu access cycles
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 rdat = reg_rdata_o;
    endtask
    task automatic mem(input logic [15:0] a, input logic w, input fro_pkg::fro_route_t e);
        @(posedge clk_i);
        cpu_req_i <= {!w, w, a};
        @(posedge clk_i);
        cpu_req_i <= '0;
        #1 chk(route_o, e);
    endtask
    task automatic intr(input logic n, input logic q);
        @(posedge clk_i);
        nmi_i <= n;
        irq_i <= q;
        @(posedge clk_i);
        nmi_i <= 1'b0;
        irq_i <= 1'b0;
        #1;
    endtask
    task automatic do_reset(input logic bm);
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        boot_mode_i <= bm;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
    endtask
    // expected route: every window adds f800
    function automatic fro_pkg::fro_route_t er(input int p, input logic v, input logic [15:0] a,
        input logic inv);
        logic hit;
        hit = (p == 3 && v && a <= 16'h007f) || (p == 1 && a >= 16'h0080 && a <= 16'h00ff)
            || (p == 2 && a >= 16'h0080 && a <= 16'h017f);
        if (a >= 16'hf800) return {3'b100, a};
        if (hit) return {3'b100, a + 16'hf800};
        return {2'b01, inv, a};
    endfunction
    // main sequence
    initial begin
        do_reset(1'b0);
        rd(fro_pkg::REG_WOC_OFS);
        chk(rdat, fro_pkg::WOC_RESET);
        rd(4'hf);
        chk(rdat, 8'h00);
        for (int v = 0; v < 2; v++) begin
            flash_high_voltage_pin_i <= v[0];
            for (int p = 0; p < 4; p++) begin
                wr(fro_pkg::REG_WOC_OFS, {p[1:0], 6'h08});
                rd(fro_pkg::REG_WOC_OFS);
                chk(rdat, {p[1:0], 6'h08});
                foreach (adr[i])
                    mem(adr[i], i[0], er(p, v[0], adr[i], 1'b0));
            end
        end
        wr(fro_pkg::REG_WOC_OFS, 8'hc5);
        @(posedge clk_i);
        hw_standby_i <= 1'b1;
        @(posedge clk_i);
        hw_standby_i <= 1'b0;
        rd(fro_pkg::REG_WOC_OFS);
        chk(rdat, fro_pkg::WOC_RESET);
        for (int k = 0; k < 2; k++) begin
            do_reset(1'b0);
            wr(fro_pkg::REG_WOC_OFS, 8'hc8);
            wr(fro_pkg::REG_FPC_OFS, 8'h01 << k);
            mem(16'h0200, 1'b0, er(3, 1'b1, 16'h0200, 1'b1));
            chk(prog_active_o | erase_active_o, 1'b1);
            intr(k == 0, k == 1);
            chk(flash_abort_o, 1'b1);
            rd(fro_pkg::REG_STAT_OFS);
            chk(rdat[fro_pkg::STAT_ABORT_BIT], 1'b1);
            mem(16'h0006, 1'b0, er(3, 1'b1, 16'h0006, 1'b1));
        end
        do_reset(1'b0);
        wr(fro_pkg::REG_WOC_OFS, 8'h48);
        mem(16'h00a0, 1'b1, er(1, 1'b1, 16'h00a0, 1'b0));
        wr(fro_pkg::REG_FPC_OFS, 8'h01);
        repeat (2) @(posedge clk_i);
        #1 chk(prog_active_o, 1'b0);
        wr(fro_pkg::REG_WOC_OFS, 8'h08);
        mem(16'hf8a0, 1'b0, er(0, 1'b1, 16'hf8a0, 1'b0));
        do_reset(1'b1);
        rd(fro_pkg::REG_WOC_OFS);
        chk(rdat[7:6], 2'h3);
        intr(1'b0, 1'b1);
        chk({nmi_take_o, irq_take_o}, 2'h0);
        intr(1'b1, 1'b0);
        chk({nmi_take_o, irq_take_o}, 2'h2);
        mem(16'hf806, 1'b1, er(3, 1'b1, 16'hf806, 1'b0));
        mem(16'hf780, 1'b0, er(3, 1'b1, 16'hf780, 1'b0));
        mem(16'h0006, 1'b0, er(3, 1'b1, 16'h0006, 1'b0));
        boot_done_i <= 1'b1;
        @(posedge clk_i);
        boot_done_i <= 1'b0;
        boot_mode_i <= 1'b0;
        rd(fro_pkg::REG_WOC_OFS);
        chk(rdat[7:6], 2'h3);
        wr(fro_pkg::REG_WOC_OFS, 8'h08);
        rd(fro_pkg::REG_WOC_OFS);
        chk(rdat, 8'h08);
        conclude();
    end
    // watchdog against a hang
    initial begin
        #2000000;
        err_count++;
        conclude();
    end
endmodule // fro_overlay_bench
